// *** rtl/wdw_watchdog.sv ***
// window watchdog: control/status registers, change protection,
// lock, tick-domain transfer of settings and the time-out engine
// assumes all inputs come from logic on sys_clk
// assumes software waits for the busy flag before a new control write
// assumes TICK_DIV sys_clk cycles make one watchdog tick
//
// Notes on behaviour
// - upper nibble 0x1..0xb enables window mode, closed time 8..8K ticks
// - lower nibble 0x1..0xb enables watchdog and picks normal time-out
// - in window mode the lower nibble sets the open window length
// - with lock set both nibbles ignore writes
// - lock bit only written to one, cleared only in debug mode
// - nonzero period at end of boot sets lock automatically
// - busy flag high from control write until transfer to tick side
// - lock bit written only after the unlock key, as control
// - busy flag needs no key and reads at any time
// - control loads from boot fuse after reset
// - clear takes two to three ticks; clears meanwhile are dropped
`timescale 1ns/10ps
module wdw_watchdog #(
    parameter int unsigned TICK_DIV = wdw_pkg::TICK_DIV
) (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire wdw_pkg::wdw_bus_req_t busReq,
    output logic [7:0]                busRdata,
    input  wire logic                 changeProtectionUnlock,
    input  wire logic                 watchdogClearInstruction,
    input  wire logic                 debugMode,
    input  wire logic                 bootDone,
    input  wire logic [7:0]           bootConfigFuse,
    output logic                      sysResetReq,
    output logic                      syncInProgressFlag
);
    import wdw_pkg::*;

    // ==========================================================
    // state record
    // ==========================================================
    // one record keeps reset and next-state code in step
    typedef struct packed {
        logic [7:0]       timeoutWindowControl;
        logic [7:0]       activeCtrl;
        logic             lock;
        logic             sync_in_progress_flag;
        logic [1:0]       syncCnt;
        logic             fuseLoad;
        logic [2:0]       ccpCnt;
        logic             clrBusy;
        logic [1:0]       clrCnt;
        wdw_mode_t        mode;
        logic [CNT_W-1:0] cnt;
        logic             wasDebug;
        logic             sysReset;
        logic [7:0]       rdata;
    } wdw_state_t;

    wdw_state_t s;
    wdw_state_t next_s;

    logic              lowPower1khzClock;
    logic [CNT_W-1:0]  winCycles;
    logic [CNT_W-1:0]  perCycles;
    logic              winValid;
    logic              perValid;
    logic              ctrlWr;
    logic              statWr;
    logic              protOk;
    logic              clrApply;
    logic [CNT_W-1:0]  cntInc;
    logic              ctrlTake;
    logic              perDone;
    logic              winDone;
    logic [7:0]        statusWord;

    // ==========================================================
    // watchdog tick enable and period decoders
    // ==========================================================
    // the slow oscillator is modelled as an enable, not a clock
    wdw_tick_div #(
        .DIV  (TICK_DIV)
    ) u_tick (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (lowPower1khzClock)
    );

    // reserved codes decode as not valid, so they act as off
    // closed window length from the upper nibble
    wdw_period_decode u_win (
        .code   (s.activeCtrl[WIN_MSB:WIN_LSB]),
        .cycles (winCycles),
        .valid  (winValid)
    );

    // time-out or open window length from the lower nibble
    wdw_period_decode u_per (
        .code   (s.activeCtrl[PER_MSB:PER_LSB]),
        .cycles (perCycles),
        .valid  (perValid)
    );

    // ==========================================================
    // bus decode
    // ==========================================================
    assign ctrlWr = busReq.wr && (busReq.addr == ADDR_CTRL);
    assign statWr = busReq.wr && (busReq.addr == ADDR_STATUS);
    // key window open; a write during fuse load would override the fuse value
    assign protOk = (s.ccpCnt != 3'h0) && !s.fuseLoad;
    assign cntInc = s.cnt + 14'h0001;
    // a write is taken only with key, no lock and no pending transfer
    assign ctrlTake = ctrlWr && protOk && !s.lock && !s.sync_in_progress_flag;

    // ==========================================================
    // status word and expiry compares
    // ==========================================================
    // spare bits read zero; busy needs no key and reads at any time
    assign statusWord = STAT_RESET
                      | (8'(s.lock) << LOCK_BIT)
                      | (8'(s.sync_in_progress_flag) << BUSY_BIT);
    // >= rather than ==: a period shortened mid-count still expires
    assign perDone = (cntInc >= perCycles);
    assign winDone = (cntInc >= winCycles);

    // ==========================================================
    // next-state logic
    // ==========================================================
    always_comb begin
        next_s          = s;
        clrApply        = 1'b0;
        // pulses and read data fall back to zero every cycle
        next_s.sysReset = 1'b0;
        next_s.rdata    = 8'h00;

        // key window runs down one step per cycle
        if (s.ccpCnt != 3'h0) begin
            next_s.ccpCnt = s.ccpCnt - 3'h1;
        end
        if (changeProtectionUnlock) begin
            next_s.ccpCnt = CCP_WINDOW;
        end

        // fuse is caught by the first clocked edge after release
        if (s.fuseLoad) begin
            next_s.fuseLoad             = 1'b0;
            next_s.timeoutWindowControl = bootConfigFuse;
            next_s.activeCtrl           = bootConfigFuse;
        end

        // control write: key needed, refused while locked or busy;
        // a refused attempt still spends the key
        if (ctrlWr && protOk) begin
            next_s.ccpCnt = 3'h0;
        end
        if (ctrlTake) begin
            next_s.timeoutWindowControl = busReq.wdata;
            next_s.sync_in_progress_flag             = 1'b1;
            next_s.syncCnt              = 2'h0;
        end

        // status write: only the lock bit is writable, under key
        // clearing the lock needs debug mode as well as the key
        if (statWr && protOk) begin
            next_s.ccpCnt = 3'h0;
            if (busReq.wdata[LOCK_BIT]) begin
                next_s.lock = 1'b1;
            end else if (debugMode) begin
                next_s.lock = 1'b0;
            end
        end

        // boot end with a running period locks the settings
        if (bootDone &&
            (s.timeoutWindowControl[PER_MSB:PER_LSB] != CODE_OFF)) begin
            next_s.lock = 1'b1;
        end

        // register read, data valid in the next cycle only
        if (busReq.rd) begin
            case (busReq.addr)
                ADDR_CTRL: begin
                    next_s.rdata = s.timeoutWindowControl;
                end
                ADDR_STATUS: begin
                    next_s.rdata = statusWord;
                end
                default: begin
                    // unmapped offsets read as zero
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // settings cross on the third tick after the write
        // active copy changes only here and at fuse load, never half way through a write
        if (s.sync_in_progress_flag && lowPower1khzClock) begin
            if (s.syncCnt == SYNC_LAST) begin
                next_s.activeCtrl = s.timeoutWindowControl;
                next_s.sync_in_progress_flag   = 1'b0;
            end else begin
                next_s.syncCnt = s.syncCnt + 2'h1;
            end
        end

        // clear request: a second one while pending is dropped
        // one pending clear at a time keeps the tick side simple
        if (watchdogClearInstruction && !s.clrBusy) begin
            next_s.clrBusy = 1'b1;
            next_s.clrCnt  = 2'h0;
        end
        if (s.clrBusy && lowPower1khzClock) begin
            if (s.clrCnt == SYNC_LAST) begin
                clrApply       = 1'b1;
                next_s.clrBusy = 1'b0;
            end else begin
                next_s.clrCnt = s.clrCnt + 2'h1;
            end
        end

        // time-out engine, advances on the tick only
        if (lowPower1khzClock) begin
            if (debugMode) begin
                // halted cpu: counter held at zero
                next_s.cnt      = '0;
                next_s.wasDebug = 1'b1;
            end else if (!perValid) begin
                next_s.mode = WDW_OFF;
                next_s.cnt  = '0;
            end else begin
                next_s.wasDebug = 1'b0;
                case (s.mode)
                    WDW_OFF: begin
                        // first closed period waits for a clear
                        next_s.mode = winValid ? WDW_ARMED
                                               : WDW_NORMAL;
                        next_s.cnt  = '0;
                    end
                    WDW_NORMAL: begin
                        if (winValid) begin
                            next_s.mode = WDW_ARMED;
                            next_s.cnt  = '0;
                        end else if (clrApply) begin
                            // a clear restarts the full time-out
                            next_s.cnt = '0;
                        end else if (perDone) begin
                            next_s.sysReset = 1'b1;
                            next_s.cnt      = '0;
                        end else begin
                            next_s.cnt = cntInc;
                        end
                    end
                    WDW_ARMED: begin
                        // normal time-out runs until the first clear
                        if (!winValid) begin
                            next_s.mode = WDW_NORMAL;
                        end else if (clrApply) begin
                            next_s.mode = WDW_CLOSED;
                            next_s.cnt  = '0;
                        end else if (perDone) begin
                            next_s.sysReset = 1'b1;
                            next_s.cnt      = '0;
                        end else begin
                            next_s.cnt = cntInc;
                        end
                    end
                    WDW_CLOSED: begin
                        // clears here come too early
                        if (!winValid) begin
                            next_s.mode = WDW_NORMAL;
                            next_s.cnt  = '0;
                        end else if (s.wasDebug) begin
                            // leaving debug skips this closed period
                            next_s.mode = WDW_ARMED;
                            next_s.cnt  = '0;
                        end else if (clrApply) begin
                            // clear too early
                            next_s.sysReset = 1'b1;
                            next_s.mode     = WDW_ARMED;
                            next_s.cnt      = '0;
                        end else if (winDone) begin
                            next_s.mode = WDW_OPEN;
                            next_s.cnt  = '0;
                        end else begin
                            next_s.cnt = cntInc;
                        end
                    end
                    WDW_OPEN: begin
                        // a clear here starts the next closed period
                        if (!winValid) begin
                            next_s.mode = WDW_NORMAL;
                            next_s.cnt  = '0;
                        end else if (s.wasDebug) begin
                            next_s.mode = WDW_ARMED;
                            next_s.cnt  = '0;
                        end else if (clrApply) begin
                            next_s.mode = WDW_CLOSED;
                            next_s.cnt  = '0;
                        end else if (perDone) begin
                            // open window ran out
                            next_s.sysReset = 1'b1;
                            next_s.mode     = WDW_ARMED;
                            next_s.cnt      = '0;
                        end else begin
                            next_s.cnt = cntInc;
                        end
                    end
                    default: begin
                        next_s.mode = WDW_OFF;
                        next_s.cnt  = '0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // state register
    // ==========================================================
    // constants only under reset; the fuse follows one edge later
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s                      <= '0;
            s.timeoutWindowControl <= CTRL_RESET;
            s.activeCtrl           <= CTRL_RESET;
            s.lock                 <= STAT_RESET[LOCK_BIT];
            s.fuseLoad             <= 1'b1;
            s.mode                 <= WDW_OFF;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    // every output comes straight from a flip-flop
    assign busRdata           = s.rdata;
    assign sysResetReq        = s.sysReset;
    assign syncInProgressFlag = s.sync_in_progress_flag;

endmodule

// *** rtl/wdw_pkg.sv ***
// constants, field layout and carrier types of the window watchdog
// assumes a 25 MHz system clock and a 1 kHz watchdog tick made from it
package wdw_pkg;

    // ==========================================================
    // clock rates and derived counts
    // ==========================================================
    localparam int unsigned SYS_CLK_HZ = 25_000_000;
    localparam int unsigned WDT_CLK_HZ = 1_000;
    // system cycles per watchdog tick
    localparam int unsigned TICK_DIV   = SYS_CLK_HZ / WDT_CLK_HZ;
    localparam int          DIV_W      = 16;

    // ==========================================================
    // register map (byte offsets on the plain register port)
    // ==========================================================
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 8;
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h1;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  STAT_RESET  = 8'h00;
    localparam int          WIN_MSB     = 7;
    localparam int          WIN_LSB     = 4;
    localparam int          PER_MSB     = 3;
    localparam int          PER_LSB     = 0;
    localparam int          LOCK_BIT    = 7;
    localparam int          BUSY_BIT    = 0;

    // ==========================================================
    // period encoding and timing counts
    // ==========================================================
    localparam int          CNT_W       = 14;
    localparam logic [3:0]  CODE_OFF    = 4'h0;
    localparam logic [3:0]  CODE_MAX    = 4'hb;
    localparam logic [13:0] BASE_CYCLES = 14'h0008;
    // transfer completes on the third tick: two to three tick periods
    localparam logic [1:0]  SYNC_LAST   = 2'h2;
    // protected write must follow the key within four cycles
    localparam logic [2:0]  CCP_WINDOW  = 3'h4;

    // ==========================================================
    // carrier and state types
    // ==========================================================
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } wdw_bus_req_t;

    typedef enum logic [2:0] {
        WDW_OFF,
        WDW_NORMAL,
        WDW_ARMED,
        WDW_CLOSED,
        WDW_OPEN
    } wdw_mode_t;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } wdw_div_state_t;

endpackage

// *** rtl/wdw_tick_div.sv ***
// divider that makes the one-cycle watchdog tick enable
// assumes DIV is at least 2 and fits in DIV_W bits
`timescale 1ns/10ps
module wdw_tick_div #(
    parameter int unsigned DIV = wdw_pkg::TICK_DIV
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    output logic      tick
);
    import wdw_pkg::*;

    wdw_div_state_t s;
    wdw_div_state_t next_s;

    // ==========================================================
    // free-running count, pulse on wrap
    // ==========================================================
    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == DIV_W'(DIV - 1)) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;

endmodule

// *** rtl/wdw_period_decode.sv ***
// maps a four-bit period code to a length in watchdog ticks
// assumes reserved codes are treated as off by the caller
`timescale 1ns/10ps
module wdw_period_decode (
    input  wire logic [3:0]  code,
    output logic [13:0]      cycles,
    output logic             valid
);
    import wdw_pkg::*;

    // ==========================================================
    // doubling decode: 0x1 gives 8 ticks, 0xb gives 8192
    // ==========================================================
    always_comb begin
        valid  = (code != CODE_OFF) && (code <= CODE_MAX);
        cycles = '0;
        if (valid) begin
            cycles = BASE_CYCLES << (code - 4'h1);
        end
    end

endmodule

// *** test/wdw_watchdog_asserts.sv ***
// checker for register port, busy flag and reset request of the watchdog
// assumes it is bound onto wdw_watchdog and sees only its ports
`timescale 1ns/10ps
module wdw_watchdog_chk #(
    parameter int unsigned TICK_DIV = wdw_pkg::TICK_DIV
) (
    input wire logic                  sys_clk,
    input wire logic                  arst_n,
    input wire wdw_pkg::wdw_bus_req_t busReq,
    input wire logic [7:0]            busRdata,
    input wire logic                  sysResetReq,
    input wire logic                  syncInProgressFlag
);
    import wdw_pkg::*;
    // loose bounds: tick phase against the write is unknown
    localparam int BUSY_LO = 2 * TICK_DIV - 2;
    localparam int BUSY_HI = 3 * TICK_DIV + 4;
    logic [31:0] busyCnt;

    // ==================================================
    // helper: cycles the busy flag has stood high
    // ==================================================
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busyCnt <= 32'h00000000;
        end else if (syncInProgressFlag) begin
            busyCnt <= busyCnt + 32'h00000001;
        end else begin
            busyCnt <= 32'h00000000;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // ==================================================
    // properties
    // ==================================================
    rd_idle_a: assert property (!$past(busReq.rd) |-> busRdata == 8'h00)
        else $error("read data not zero outside read answer");
    stat_rsvd_a: assert property (busReq.rd && busReq.addr == ADDR_STATUS
        |=> busRdata[6:1] == 6'h00)
        else $error("status spare bits not zero");
    busy_rd_a: assert property (busReq.rd && busReq.addr == ADDR_STATUS
        |=> busRdata[BUSY_BIT] == $past(syncInProgressFlag))
        else $error("status busy bit differs from busy flag");
    unmap_rd_a: assert property (busReq.rd && busReq.addr > ADDR_STATUS
        |=> busRdata == 8'h00)
        else $error("unmapped read not zero");
    busy_cause_a: assert property ($rose(syncInProgressFlag)
        |-> $past(busReq.wr && busReq.addr == ADDR_CTRL))
        else $error("busy rose without control write");
    busy_max_a: assert property (syncInProgressFlag
        |-> busyCnt <= BUSY_HI)
        else $error("busy flag stuck high");
    busy_min_a: assert property ($fell(syncInProgressFlag)
        |-> busyCnt >= BUSY_LO)
        else $error("busy flag cleared too early");
    rst_pulse_a: assert property (sysResetReq |=> !sysResetReq)
        else $error("reset request longer than one cycle");
endmodule

bind wdw_watchdog wdw_watchdog_chk #(.TICK_DIV(TICK_DIV)) u_wdw_watchdog_chk (
    .sys_clk            (sys_clk),
    .arst_n             (arst_n),
    .busReq             (busReq),
    .busRdata           (busRdata),
    .sysResetReq        (sysResetReq),
    .syncInProgressFlag (syncInProgressFlag)
);

// *** test/tb_top.sv ***
// self-checking bench for the window watchdog
// assumes a short tick divider so time-outs take 32 to 128 cycles
`timescale 1ns/10ps
module tb_top;
    import wdw_pkg::*;
    localparam int unsigned DIV = 4;
    logic         sys_clk;
    logic         arst_n;
    wdw_bus_req_t busReq;
    logic [7:0]   busRdata;
    logic         changeProtectionUnlock;
    logic         watchdogClearInstruction;
    logic         debugMode;
    logic         bootDone;
    logic [7:0]   bootConfigFuse;
    logic         sysResetReq;
    logic         syncInProgressFlag;
    logic [7:0]   expQ[$];
    logic         rdPrev = 1'b0;
    int           rstCnt = 0;
    int           nFail = 0;
    int           testsRun = 0;
    int           cyc = 0;
    int           seed;
    int           gap;
    int           n0;

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    wdw_watchdog #(.TICK_DIV(DIV)) u_wdw_watchdog (
        .sys_clk                  (sys_clk),
        .arst_n                   (arst_n),
        .busReq                   (busReq),
        .busRdata                 (busRdata),
        .changeProtectionUnlock   (changeProtectionUnlock),
        .watchdogClearInstruction (watchdogClearInstruction),
        .debugMode                (debugMode),
        .bootDone                 (bootDone),
        .bootConfigFuse           (bootConfigFuse),
        .sysResetReq              (sysResetReq),
        .syncInProgressFlag       (syncInProgressFlag)
    );

    // ==================================================
    // shared tasks
    // ==================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // k: cycles from key to write, 0 sends no key
    task automatic wrReg(input logic [3:0] a, input logic [7:0] d,
                         input int k);
        @(posedge sys_clk);
        if (k > 0) begin
            changeProtectionUnlock <= 1'b1;
            @(posedge sys_clk);
            changeProtectionUnlock <= 1'b0;
            repeat (k - 1) @(posedge sys_clk);
        end
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        busReq <= '0;
    endtask

    // expectation noted here, compared by the monitor
    task automatic rdReg(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        expQ.push_back(e);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        busReq <= '0;
    endtask

    task automatic clr(input int pre);
        repeat (pre) @(posedge sys_clk);
        watchdogClearInstruction <= 1'b1;
        @(posedge sys_clk);
        watchdogClearInstruction <= 1'b0;
    endtask

    // bounded wait for a reset pulse, n is cycles waited
    task automatic waitRst(input int lim, output int n);
        n = 0;
        while (n < lim) begin
            @(posedge sys_clk);
            n++;
            if (sysResetReq === 1'b1) break;
        end
    endtask

    task automatic waitIdle();
        repeat (40) begin
            @(posedge sys_clk);
            if (syncInProgressFlag === 1'b0) break;
        end
    endtask

    // ==================================================
    // monitor: read answers and reset pulses, plus hang guard
    // ==================================================
    always @(posedge sys_clk) begin
        rdPrev <= busReq.rd;
        if (rdPrev === 1'b1) chk(busRdata, expQ.pop_front());
        if (sysResetReq === 1'b1) rstCnt <= rstCnt + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            nFail++;
            endOfTest();
        end
    end

    // ==================================================
    // main sequence
    // ==================================================
    initial begin
        seed = 32'hd4600bf0;
        busReq = '0;
        changeProtectionUnlock = 1'b0;
        watchdogClearInstruction = 1'b0;
        debugMode = 1'b0;
        bootDone = 1'b0;
        bootConfigFuse = 8'h01;
        arst_n = 1'b0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rdReg(ADDR_CTRL, 8'h01);
        rdReg(ADDR_STATUS, 8'h00);
        rdReg(4'(($random(seed) & 32'h7fff) % 14 + 2), 8'h00);
        wrReg(ADDR_CTRL, 8'($random(seed)), 0);
        rdReg(ADDR_CTRL, 8'h01);
        // fuse period code 1: eight ticks between resets
        waitRst(200, gap);
        waitRst(200, gap);
        chk(8'(gap >= 8 * DIV - 2 && gap <= 8 * DIV + 2), 8'h01);
        // let the monitor's count of the pulse just seen settle first
        @(posedge sys_clk);
        n0 = rstCnt;
        repeat (10) clr(15);
        chk(8'(rstCnt - n0), 8'h00);
        // boot lock, then lock holds against writes
        @(posedge sys_clk);
        bootDone <= 1'b1;
        @(posedge sys_clk);
        bootDone <= 1'b0;
        rdReg(ADDR_STATUS, 8'h80);
        wrReg(ADDR_CTRL, 8'h02, 1);
        rdReg(ADDR_CTRL, 8'h01);
        wrReg(ADDR_STATUS, 8'h00, 1);
        rdReg(ADDR_STATUS, 8'h80);
        debugMode <= 1'b1;
        wrReg(ADDR_STATUS, 8'h00, 0);
        rdReg(ADDR_STATUS, 8'h80);
        wrReg(ADDR_STATUS, 8'h00, 1);
        rdReg(ADDR_STATUS, 8'h00);
        debugMode <= 1'b0;
        // key window edge: five cycles late refused, four taken
        wrReg(ADDR_CTRL, 8'h03, 5);
        rdReg(ADDR_CTRL, 8'h01);
        wrReg(ADDR_CTRL, 8'h03, 4);
        rdReg(ADDR_CTRL, 8'h03);
        rdReg(ADDR_STATUS, 8'h01);
        waitIdle();
        rdReg(ADDR_STATUS, 8'h00);
        // period codes double the time-out
        for (int c = 1; c <= 3; c++) begin
            wrReg(ADDR_CTRL, 8'(c), 1);
            waitIdle();
            waitRst(1200, gap);
            waitRst(1200, gap);
            chk(8'(gap >= (8 << (c - 1)) * DIV - 2
                && gap <= (8 << (c - 1)) * DIV + 2), 8'h01);
        end
        // window: closed 16 ticks, open 8 ticks
        wrReg(ADDR_CTRL, 8'h21, 1);
        waitIdle();
        n0 = rstCnt;
        clr(0);
        clr(DIV);
        clr(11 * DIV);
        chk(8'(rstCnt - n0), 8'h00);
        waitRst(6 * DIV, gap);
        chk(8'(gap < 6 * DIV), 8'h01);
        @(posedge sys_clk);
        n0 = rstCnt;
        clr(2);
        clr(21 * DIV);
        waitRst(20 * DIV, gap);
        chk(8'(rstCnt - n0), 8'h00);
        waitRst(20 * DIV, gap);
        chk(8'(sysResetReq), 8'h01);
        endOfTest();
    end
endmodule
